// *** hdl/pcb_pkg.sv ***
// package of register map, field positions and reset values for the pll control block
package pcb_pkg;

  // byte addresses on the register bus
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] BW_OFFSET   = 4'h4;

  // control register field positions
  localparam int CTRL_IE_BIT    = 7;
  localparam int CTRL_FLAG_BIT  = 6;
  localparam int CTRL_ON_BIT    = 5;
  localparam int CTRL_SEL_BIT   = 4;
  localparam int CTRL_PRE_LO    = 2;
  localparam int CTRL_RANGE_LO  = 0;

  // bandwidth register field positions
  localparam int BW_AUTO_BIT    = 7;
  localparam int BW_LOCK_BIT    = 6;
  localparam int BW_ACQ_BIT     = 5;

  // reset values
  localparam logic       ON_RESET    = 1'b1;
  localparam logic       SEL_RESET   = 1'b0;
  localparam logic [1:0] PRE_RESET   = 2'h0;
  localparam logic [1:0] RANGE_RESET = 2'h0;

  // edges of each source to wait through while switching
  localparam logic [1:0] SWITCH_EDGES = 2'h3;

  typedef enum logic {PCB_RUN, PCB_HOLD} pcb_switch_t;

endpackage

// *** hdl/pcb_clock_switch.sv ***
// transition control and divide-by-two for the base clock
`timescale 1ns/10ps
module pcb_clock_switch (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // source clock levels, sampled as data, and whether the vco is running
  input  wire logic oscClock,
  input  wire logic dividedVcoClock,
  input  wire logic vcoRunning,
  // selection and output
  input  wire logic select,
  output logic      baseClockOut,
  output logic      switching
);

  logic                 oscPrev;
  logic                 vcoPrev;
  logic                 curSel;
  logic [1:0]           oscCount;
  logic [1:0]           vcoCount;
  pcb_pkg::pcb_switch_t state;

  // rising edges of each source, seen in the first cycle the source reads high
  wire oscEdge = oscClock & ~oscPrev;
  wire vcoEdge = dividedVcoClock & ~vcoPrev;
  wire selEdge = curSel ? vcoEdge : oscEdge;
  // a stopped vco is not waited on, else the switch would never finish
  wire oscDone = (oscCount == pcb_pkg::SWITCH_EDGES);
  wire vcoDone = (vcoCount == pcb_pkg::SWITCH_EDGES) | ~vcoRunning;

  // edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oscPrev <= 1'b0;
      vcoPrev <= 1'b0;
    end else begin
      oscPrev <= oscClock;
      vcoPrev <= dividedVcoClock;
    end
  end

  // switch state: run on current source or hold static while draining
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= pcb_pkg::PCB_RUN;
      curSel   <= pcb_pkg::SEL_RESET;
      oscCount <= 2'h0;
      vcoCount <= 2'h0;
    end else begin
      unique case (state)
        pcb_pkg::PCB_RUN: begin
          oscCount <= 2'h0;
          vcoCount <= 2'h0;
          if (select != curSel) begin
            state <= pcb_pkg::PCB_HOLD;
          end
        end
        pcb_pkg::PCB_HOLD: begin
          if (oscEdge && !oscDone) begin
            oscCount <= oscCount + 2'h1;
          end
          if (vcoEdge && !vcoDone) begin
            vcoCount <= vcoCount + 2'h1;
          end
          if (oscDone && vcoDone) begin
            curSel <= select;
            state  <= pcb_pkg::PCB_RUN;
          end
        end
      endcase
    end
  end

  // output toggles on each selected source edge, frozen while holding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baseClockOut <= 1'b0;
      switching    <= 1'b0;
    end else begin
      switching <= (state == pcb_pkg::PCB_HOLD);
      if (state == pcb_pkg::PCB_RUN && selEdge) begin
        baseClockOut <= ~baseClockOut;
      end
    end
  end

endmodule

// *** hdl/pcb_pll_control.sv ***
// pll control and bandwidth registers with clock-select interlocks
`timescale 1ns/10ps
module pcb_pll_control (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // wishbone slave
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [3:0] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]     dat_o,
  output logic            ack_o,
  // analog pll status and linear range register value
  input  wire logic       pllLocked,
  input  wire logic       pllTracking,
  input  wire logic [7:0] linearRange,
  // source clock levels
  input  wire logic       oscClock,
  input  wire logic       dividedVcoClock,
  // pll controls
  output logic            pllEnable,
  output logic            vcoClockEnable,
  output logic            autoBandwidth,
  output logic            acquisitionNot,
  output logic [1:0]      prescaleSel,
  output logic [1:0]      vcoPow2Range,
  // system side
  output logic            baseClockOut,
  output logic            baseSwitching,
  output logic            cpuIrq
);

  // stored control state
  logic       lockIrqEnable;
  logic       lockChangeFlag;
  logic       pllPowerOn;
  logic       baseClockSelect;
  logic [1:0] prescale;
  logic [1:0] vcoRange;
  logic       autoMode;
  logic       lockBit;
  logic       manualAcq;
  logic       readPending;

  // bus decode
  wire busReq    = cyc_i & stb_i & ~ack_o;
  wire hitCtrl   = (adr_i == pcb_pkg::CTRL_OFFSET);
  wire hitBw     = (adr_i == pcb_pkg::BW_OFFSET);
  wire laneOk    = sel_i[0];
  wire wrCtrl    = busReq & we_i & hitCtrl & laneOk;
  wire wrBw      = busReq & we_i & hitBw & laneOk;
  // the read happens at the edge that gives ack
  wire rdCtrl    = busReq & ~we_i & hitCtrl;
  wire [7:0] wd  = dat_i[7:0];

  // linear range zero forbids the vco as base clock source
  wire rangeZero = (linearRange == 8'h00);

  // requested field values from a control or bandwidth write
  wire wIe       = wd[pcb_pkg::CTRL_IE_BIT];
  wire wOn       = wd[pcb_pkg::CTRL_ON_BIT];
  wire wSel      = wd[pcb_pkg::CTRL_SEL_BIT];
  wire [1:0] wPre   = wd[pcb_pkg::CTRL_PRE_LO +: 2];
  wire [1:0] wRange = wd[pcb_pkg::CTRL_RANGE_LO +: 2];
  wire wAuto     = wd[pcb_pkg::BW_AUTO_BIT];
  wire wAcq      = wd[pcb_pkg::BW_ACQ_BIT];

  // interlocks use the values held before the write, so one write can
  // clear power-on and set select together
  wire next_pllPowerOn = (wrCtrl && !(baseClockSelect && !wOn)) ? wOn
                       : pllPowerOn;
  wire selAllowed      = pllPowerOn & ~rangeZero;
  wire next_baseClockSelect = rangeZero ? 1'b0
                            : (wrCtrl && (!wSel || selAllowed)) ? wSel
                            : baseClockSelect;

  // lock bit follows the detector only in automatic mode
  wire next_lockBit = autoMode & pllLocked;
  wire lockToggle   = next_lockBit ^ lockBit;

  // value shown on the acquisition-not bit and driven to the pll
  wire acqView = autoMode ? pllTracking : manualAcq;

  // read views, gated by mode; unused bits read as zero
  wire [7:0] ctrlView = {lockIrqEnable & autoMode,
                         lockChangeFlag & autoMode,
                         pllPowerOn,
                         baseClockSelect,
                         prescale,
                         vcoRange};
  wire [7:0] bwView   = {autoMode,
                         lockBit,
                         acqView,
                         5'h00};
  wire [7:0] readSel  = hitCtrl ? ctrlView
                      : hitBw   ? bwView
                      : 8'h00;

  // bus answer: ack one cycle after the request, data with it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= busReq;
      dat_o <= busReq ? {24'h00_0000, readSel} : 32'h0000_0000;
    end
  end

  // read of control register marks the flag for clearing at ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readPending <= 1'b0;
    end else begin
      readPending <= rdCtrl;
    end
  end

  // power-on and base select with their interlocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pllPowerOn      <= pcb_pkg::ON_RESET;
      baseClockSelect <= pcb_pkg::SEL_RESET;
    end else begin
      pllPowerOn      <= next_pllPowerOn;
      baseClockSelect <= next_baseClockSelect;
    end
  end

  // prescaler and range fields, frozen while the pll runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale <= pcb_pkg::PRE_RESET;
      vcoRange <= pcb_pkg::RANGE_RESET;
    end else if (wrCtrl && !pllPowerOn) begin
      prescale <= wPre;
      vcoRange <= wRange;
    end
  end

  // interrupt enable, writable only in automatic mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lockIrqEnable <= 1'b0;
    end else if (wrCtrl && autoMode) begin
      lockIrqEnable <= wIe;
    end
  end

  // lock change flag: a toggle in the same cycle as a clear wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lockChangeFlag <= 1'b0;
    end else if (lockToggle) begin
      lockChangeFlag <= 1'b1;
    end else if (readPending) begin
      lockChangeFlag <= 1'b0;
    end
  end

  // bandwidth mode and lock status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      autoMode <= 1'b0;
      lockBit  <= 1'b0;
    end else begin
      lockBit <= next_lockBit;
      if (wrBw) begin
        autoMode <= wAuto;
      end
    end
  end

  // manual acquisition-not store, untouched while automatic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      manualAcq <= 1'b0;
    end else if (wrBw && !autoMode) begin
      manualAcq <= wAcq;
    end
  end

  // registered outputs to the analog pll and the cpu
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pllEnable      <= 1'b0;
      vcoClockEnable <= 1'b0;
      autoBandwidth  <= 1'b0;
      acquisitionNot <= 1'b0;
      prescaleSel    <= pcb_pkg::PRE_RESET;
      vcoPow2Range   <= pcb_pkg::RANGE_RESET;
      cpuIrq         <= 1'b0;
    end else begin
      pllEnable      <= pllPowerOn & ~rangeZero;
      vcoClockEnable <= pllPowerOn & ~rangeZero;
      autoBandwidth  <= autoMode;
      acquisitionNot <= acqView;
      prescaleSel    <= prescale;
      vcoPow2Range   <= vcoRange;
      cpuIrq         <= lockChangeFlag & lockIrqEnable & autoMode;
    end
  end

  // base clock transition control and divide-by-two
  pcb_clock_switch uSwitch (
    .clk             (clk),
    .rst             (rst),
    .oscClock        (oscClock),
    .dividedVcoClock (dividedVcoClock),
    .vcoRunning      (pllEnable),
    .select          (baseClockSelect),
    .baseClockOut    (baseClockOut),
    .switching       (baseSwitching)
  );

endmodule

// *** dv/pcb_properties.sv ***
// concurrent checks on the ports of the pll control block
`timescale 1ns/10ps
module pcb_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  // pll side
  input wire logic [7:0]  linearRange,
  input wire logic        pllTracking,
  input wire logic        pllEnable,
  input wire logic        vcoClockEnable,
  input wire logic        autoBandwidth,
  input wire logic        acquisitionNot,
  input wire logic [1:0]  prescaleSel,
  input wire logic [1:0]  vcoPow2Range,
  input wire logic        baseClockOut,
  input wire logic        baseSwitching,
  input wire logic        cpuIrq
);
  // one clock domain, reset disables every check
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered after one cycle");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_upper_zero: assert property (dat_o[31:8] == 24'h00_0000 &&
    (ack_o || dat_o == 32'h0000_0000)) else $error("read data not zero outside its ack");
  chk_range_zero: assert property (linearRange == 8'h00 |=> !pllEnable)
    else $error("pll enabled with zero linear range");
  chk_vco_enable: assert property (vcoClockEnable == pllEnable)
    else $error("vco clock enable differs from pll enable");
  chk_acq_auto: assert property (autoBandwidth && $past(autoBandwidth) &&
    $past(autoBandwidth, 2) |-> acquisitionNot == $past(pllTracking))
    else $error("acquisition status not following tracking in auto mode");
  chk_fields_frozen: assert property (pllEnable && $past(pllEnable) &&
    $past(pllEnable, 2) |-> $stable(prescaleSel) && $stable(vcoPow2Range))
    else $error("prescale or range changed while pll runs");
  chk_hold_static: assert property (baseSwitching && $past(baseSwitching)
    |-> $stable(baseClockOut)) else $error("base clock moved during switch");
  chk_switch_bound: assert property ($rose(baseSwitching) |-> ##[1:200] !baseSwitching)
    else $error("clock switch did not complete");
  chk_irq_auto: assert property (cpuIrq |-> autoBandwidth || $past(autoBandwidth))
    else $error("interrupt request outside auto mode");
endmodule

// *** dv/pcb_analog_model.sv ***
// oscillator and analog pll stand-in feeding the control block
`timescale 1ns/10ps
module pcb_analog_model (
  // clock
  input  wire logic clk,
  // controls
  input  wire logic vcoClockEnable,
  input  wire logic lockCmd,
  // source clocks and status
  output logic      oscClock,
  output logic      dividedVcoClock,
  output logic      pllLocked,
  output logic      pllTracking
);
  logic [2:0] oscCount = 3'h0;
  logic       vcoPhase = 1'b0;
  // oscillator runs free, vco stands still at low while disabled
  always @(posedge clk) begin
    oscCount <= oscCount + 3'h1;
    vcoPhase <= vcoClockEnable ? ~vcoPhase : 1'b0;
  end
  assign oscClock        = oscCount[2];
  assign dividedVcoClock = vcoPhase;
  // lock only possible while the vco runs
  assign pllLocked       = lockCmd & vcoClockEnable;
  assign pllTracking     = pllLocked;
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the pll control block
`timescale 1ns/10ps
module tb_top;
  localparam logic [3:0] ctrlAdr = pcb_pkg::CTRL_OFFSET;
  localparam logic [3:0] bwAdr   = pcb_pkg::BW_OFFSET;
  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic        cyc_i       = 1'b0;
  logic        we_i        = 1'b0;
  logic [3:0]  adr_i       = 4'h0;
  logic [3:0]  sel_i       = 4'h0;
  logic [31:0] dat_i       = 32'h0000_0000;
  logic [7:0]  linearRange = 8'h40;
  logic        lockCmd     = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o, oscClock, dividedVcoClock, pllLocked, pllTracking;
  logic        pllEnable, vcoClockEnable, autoBandwidth, acquisitionNot;
  logic [1:0]  prescaleSel, vcoPow2Range;
  logic        baseClockOut, baseSwitching, cpuIrq;
  int          mismatches  = 0;
  int          checked     = 0;
  pcb_pll_control pcb_pll_control_inst (.stb_i(cyc_i), .*);
  pcb_analog_model pcb_analog_model_inst (.*);
  always #5 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle, request held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    cyc_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h00_0000, d};
    do @(posedge clk); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk($sformatf("reg%0h", a), q, e);
  endtask
  // let a source change finish, then count base clock edges
  task automatic watch(input int lo, input int hi);
    int n;
    logic last;
    for (n = 0; n < 8 && baseSwitching !== 1'b1; n++) @(posedge clk);
    for (n = 0; n < 200 && baseSwitching !== 1'b0; n++) @(posedge clk);
    n = 0;
    last = baseClockOut;
    repeat (64) begin
      @(posedge clk);
      if (baseClockOut !== last) n++;
      last = baseClockOut;
    end
    chk("toggles", 8'(n >= lo && n <= hi), 8'h01);
  endtask
  task automatic t_reset;
    rd(ctrlAdr, 8'h20);
    rd(bwAdr, 8'h00);
    rd(4'h8, 8'h00);
    chk("enable", {7'h00, pllEnable}, 8'h01);
  endtask
  // manual then automatic bandwidth, lock flag and request line
  task automatic t_auto;
    wr(bwAdr, 8'h20);
    rd(bwAdr, 8'h20);
    chk("acq", {7'h00, acquisitionNot}, 8'h01);
    wr(ctrlAdr, 8'hA0);
    rd(ctrlAdr, 8'h20);
    wr(bwAdr, 8'hA0);
    lockCmd <= 1'b1;
    repeat (4) @(posedge clk);
    rd(bwAdr, 8'hE0);
    chk("auto", {7'h00, autoBandwidth}, 8'h01);
    rd(ctrlAdr, 8'h60);
    rd(ctrlAdr, 8'h20);
    wr(ctrlAdr, 8'hA0);
    lockCmd <= 1'b0;
    repeat (4) @(posedge clk);
    chk("irq", {7'h00, cpuIrq}, 8'h01);
    rd(ctrlAdr, 8'hE0);
    rd(ctrlAdr, 8'hA0);
    chk("irq", {7'h00, cpuIrq}, 8'h00);
    wr(bwAdr, 8'h00);
    rd(bwAdr, 8'h20);
    chk("auto", {7'h00, autoBandwidth}, 8'h00);
    rd(ctrlAdr, 8'h20);
  endtask
  task automatic t_switch;
    wr(ctrlAdr, 8'h30);
    watch(31, 33);
    wr(ctrlAdr, 8'h00);
    watch(7, 9);
    rd(ctrlAdr, 8'h20);
  endtask
  task automatic t_fields;
    logic [7:0] d;
    wr(ctrlAdr, 8'h00);
    rd(ctrlAdr, 8'h00);
    chk("enable", {7'h00, pllEnable}, 8'h00);
    wr(ctrlAdr, 8'h10);
    rd(ctrlAdr, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'(i * 4 + i % 3);
      wr(ctrlAdr, d);
      rd(ctrlAdr, d);
      chk("prescale", {6'h00, prescaleSel}, 8'(i));
      chk("range", {6'h00, vcoPow2Range}, 8'(i % 3));
    end
    wr(bwAdr, 8'h00);
    wr(ctrlAdr, 8'h2C);
    wr(ctrlAdr, 8'h21);
    rd(ctrlAdr, 8'h2C);
  endtask
  task automatic t_zero;
    linearRange <= 8'h00;
    repeat (3) @(posedge clk);
    chk("enable", {7'h00, pllEnable}, 8'h00);
    wr(ctrlAdr, 8'h3C);
    rd(ctrlAdr, 8'h2C);
    linearRange <= 8'h40;
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence after a 16 cycle reset
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_auto();
    t_switch();
    t_fields();
    t_zero();
    give_verdict();
  end
  // watchdog well beyond the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule
bind pcb_pll_control pcb_properties pcb_properties_inst (.*);
